// [core/adcr_pkg.sv]
// register map, field layouts and types of the converter control register set
package adcr_pkg;

  // ==========================================================================
  // register byte addresses on the avalon slave
  // ==========================================================================
  localparam logic [4:0] OFS_CTRL0    = 5'h00;
  localparam logic [4:0] OFS_CTRL1    = 5'h04;
  localparam logic [4:0] OFS_CTRL2    = 5'h08;
  localparam logic [4:0] OFS_PIN_LOW  = 5'h0c;
  localparam logic [4:0] OFS_PIN_HIGH = 5'h10;
  localparam logic [4:0] OFS_RES_HIGH = 5'h14;
  localparam logic [4:0] OFS_RES_LOW  = 5'h18;

  // ==========================================================================
  // reset values, masks and codes
  // ==========================================================================
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] CTRL1_RD_MASK  = 8'he7;
  localparam logic [3:0] RST_NIBBLE     = 4'h0;
  localparam logic [3:0] CHAN_LAST      = 4'hb;
  localparam logic [2:0] SRC_EXT_A      = 3'h0;
  localparam logic [2:0] SRC_EXT_B      = 3'h4;
  localparam logic [3:0] REF_SUPPLY     = 4'h0;
  localparam logic [3:0] REF_EXT_FIRST  = 4'h1;
  localparam logic [3:0] REF_EXT_LAST   = 4'h4;
  localparam logic [3:0] REF_RSVD       = 4'h9;
  localparam logic [3:0] REF_BG_FIRST   = 4'ha;
  localparam logic [3:0] REF_BG_LAST    = 4'hc;
  localparam logic [3:0] REF_BG_OFFSET  = 4'h8;
  localparam int         CHANNELS       = 12;

  // ==========================================================================
  // register layouts
  // ==========================================================================
  typedef struct packed {
    logic       start;
    logic       conversion_busy_flag;
    logic       converter_enable_bit;
    logic       result_format_bit;
    logic [3:0] external_channel_field;
  } adcr_ctrl0_t;

  typedef struct packed {
    logic [2:0] input_source_field;
    logic [1:0] unused;
    logic [2:0] clock_divider_field;
  } adcr_ctrl1_t;

  typedef struct packed {
    logic       gain_amp_enable;
    logic       bandgap_enable;
    logic       ext_ref_input_select;
    logic       ref_output_select;
    logic [3:0] reference_source_field;
  } adcr_ctrl2_t;

  typedef enum logic [2:0] {
    REFK_NONE   = 3'h0,
    REFK_SUPPLY = 3'h1,
    REFK_EXT    = 3'h2,
    REFK_BG     = 3'h4
  } adcr_ref_kind_t;

  typedef enum logic [2:0] {
    CV_IDLE  = 3'b001,
    CV_ARMED = 3'b010,
    CV_BUSY  = 3'b100
  } adcr_conv_t;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } adcr_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } adcr_avs_resp_t;

  typedef struct packed {
    logic           converterOn;
    logic [11:0]    channelRoute;
    logic [11:0]    pinAnalog;
    logic [5:0]     internalSel;
    logic           gainAmpOn;
    logic           bandgapOn;
    logic           extRefConnect;
    logic           refOutDrive;
    adcr_ref_kind_t refKind;
    logic [2:0]     refGain;
    logic           gainBypass;
  } adcr_analog_t;

  typedef struct packed {
    adcr_ctrl0_t  c0;
    adcr_ctrl1_t  c1;
    adcr_ctrl2_t  c2;
    logic [7:0]   pinLow;
    logic [3:0]   pinHigh;
    logic [11:0]  result;
    adcr_conv_t   conv;
    logic [6:0]   divCnt;
    logic         ack;
    logic [7:0]   rdData;
    logic         convStart;
    logic         convClkTick;
    logic         convDone;
    adcr_analog_t ctrl;
  } adcr_state_t;

endpackage : adcr_pkg

// [core/adcr_control.sv]
// converter control register set: avalon slave, start/busy sequencing, routing and references
// ============================================================================
// Contract
// RULE1 - a conversion launches only after start goes high then low again
// RULE2 - busy rises on launch and falls when the conversion completes
// RULE3 - busy is read only; writes to its bit are ignored
// RULE4 - enable bit powers the converter on, clearing it powers it off
// RULE5 - while disabled both result bytes keep their contents
// RULE6 - format 0: high=bits 11..4, low=bits 3..0; format 1: high=11..8, low=7..0
// RULE7 - unused result bits read zero; left format puts low nibble on top
// RULE8 - channel codes 0..11 route that channel; 12..15 route nothing
// RULE9 - source 000/100 external; 001..011 supply ratios; 101..111 reference ratios
// RULE10 - an internal source disconnects the external channel regardless of channel code
// RULE11 - input/clock bits 4..3 and upper pin-enable bits 7..4 read zero
// RULE12 - clock divider code n divides the system clock by two to the n
// RULE13 - gain amp enable switches on the amplifier and internal reference
// RULE14 - bandgap powers when enabled, else off unless low-voltage detect or reset needs it; code also requires the converter enable bit
// RULE15 - software waits the bandgap settle time before starting a conversion
// RULE16 - software enables the bandgap before choosing a bandgap reference code
// RULE17 - external reference select connects the reference input pin when set
// RULE18 - reference output select drives the reference out on its pin
// RULE19 - reference codes: supply, external times 1..4, bandgap times 2..4, 1001 reserved
// RULE20 - supply or bandgap reference disconnects the external reference pin
// RULE21 - the gain amplifier never scales a supply reference
// RULE22 - twelve pin-enable bits make each pin an analog channel when set
// RULE23 - software clears other pin functions before using the reference pins
// RULE24 - completion raises the converter interrupt request
// RULE25 - reference codes 0101..1000 select no defined source
// RULE26 - power-on reset clears all five control registers
// ============================================================================
module adcr_control (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire adcr_pkg::adcr_avs_req_t avsReq,
  output adcr_pkg::adcr_avs_resp_t     avsResp,
  input  wire logic                    coreDone,
  input  wire logic [11:0]             coreResult,
  input  wire logic                    lvdEnable,
  input  wire logic                    lvrEnable,
  output adcr_pkg::adcr_analog_t       analogCtrl,
  output logic                         convStart,
  output logic                         convClkTick,
  output logic                         convDone
);

  // ==========================================================================
  // reset release
  // ==========================================================================
  logic [1:0] rstPipe;
  logic       rstSync_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end

  assign rstSync_n = rstPipe[1];

  // ==========================================================================
  // decoders
  // ==========================================================================
  function automatic adcr_pkg::adcr_ref_kind_t refKindOf(input logic [3:0] code);
    if (code == adcr_pkg::REF_SUPPLY || code > adcr_pkg::REF_BG_LAST)
      refKindOf = adcr_pkg::REFK_SUPPLY;
    else if (code >= adcr_pkg::REF_EXT_FIRST && code <= adcr_pkg::REF_EXT_LAST)
      refKindOf = adcr_pkg::REFK_EXT;
    else if (code >= adcr_pkg::REF_BG_FIRST)
      refKindOf = adcr_pkg::REFK_BG;
    else
      refKindOf = adcr_pkg::REFK_NONE; // RULE25
  endfunction : refKindOf

  function automatic logic [6:0] divMask(input logic [2:0] code);
    logic [7:0] full;
    full    = (8'h01 << code) - 8'h01;
    divMask = full[6:0];
  endfunction : divMask

  function automatic logic isExtSource(input logic [2:0] src);
    isExtSource = (src == adcr_pkg::SRC_EXT_A) || (src == adcr_pkg::SRC_EXT_B);
  endfunction : isExtSource

  // ==========================================================================
  // state
  // ==========================================================================
  adcr_pkg::adcr_state_t st;
  adcr_pkg::adcr_state_t next_st;

  logic                      accept;
  logic                      wrAccept;
  logic                      launch;
  logic                      finish;
  logic [7:0]                wrByte;
  logic [7:0]                rdByte;
  adcr_pkg::adcr_ref_kind_t  refKind;
  logic [6:0]                mask;
  logic [11:0]               route;

  // answer comes one cycle after the request; the extra cycle lets read data be registered
  assign accept   = (avsReq.read || avsReq.write) && st.ack;
  assign wrAccept = avsReq.write && st.ack && avsReq.byteenable[0];
  assign wrByte   = avsReq.writedata[7:0];
  assign avsResp = '{readdata:    {24'h000000, st.rdData},
                     waitrequest: (avsReq.read || avsReq.write) && !st.ack};

  // launch on the falling half of a completed start pulse
  assign launch = (st.conv == adcr_pkg::CV_ARMED) && wrAccept
               && (avsReq.address == adcr_pkg::OFS_CTRL0) && !wrByte[7]
               && st.c0.converter_enable_bit; // RULE1
  assign finish = (st.conv == adcr_pkg::CV_BUSY) && coreDone;

  assign refKind = refKindOf(st.c2.reference_source_field);
  assign mask    = divMask(st.c1.clock_divider_field);

  always_comb
  begin
    route = 12'h000;
    if (isExtSource(st.c1.input_source_field) && st.c0.external_channel_field <= adcr_pkg::CHAN_LAST)
      route[st.c0.external_channel_field] = 1'b1; // RULE8 RULE10
  end

  // read data mux; result layout follows the format bit
  always_comb
  begin
    rdByte = adcr_pkg::RST_BYTE;
    case (avsReq.address)
      adcr_pkg::OFS_CTRL0:    rdByte = st.c0;
      adcr_pkg::OFS_CTRL1:    rdByte = st.c1 & adcr_pkg::CTRL1_RD_MASK; // RULE11
      adcr_pkg::OFS_CTRL2:    rdByte = st.c2;
      adcr_pkg::OFS_PIN_LOW:  rdByte = st.pinLow;
      adcr_pkg::OFS_PIN_HIGH: rdByte = {adcr_pkg::RST_NIBBLE, st.pinHigh}; // RULE11
      adcr_pkg::OFS_RES_HIGH:
        rdByte = st.c0.result_format_bit ? {4'h0, st.result[11:8]}
                                         : st.result[11:4]; // RULE6 RULE7
      adcr_pkg::OFS_RES_LOW:
        rdByte = st.c0.result_format_bit ? st.result[7:0]
                                         : {st.result[3:0], 4'h0}; // RULE6 RULE7
      default:                rdByte = adcr_pkg::RST_BYTE;
    endcase
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    next_st = st;
    next_st.ack = (avsReq.read || avsReq.write) && !st.ack;
    if (avsReq.read && !st.ack)
      next_st.rdData = rdByte;
    next_st.convStart = launch;
    next_st.convDone  = finish; // RULE24

    if (wrAccept)
    begin
      case (avsReq.address)
        adcr_pkg::OFS_CTRL0:
        begin
          // busy bit position is skipped so software cannot touch it
          next_st.c0.start                  = wrByte[7];
          next_st.c0.converter_enable_bit   = wrByte[5]; // RULE4
          next_st.c0.result_format_bit      = wrByte[4];
          next_st.c0.external_channel_field = wrByte[3:0]; // RULE3
        end
        adcr_pkg::OFS_CTRL1:    next_st.c1 = wrByte & adcr_pkg::CTRL1_RD_MASK;
        adcr_pkg::OFS_CTRL2:    next_st.c2 = wrByte;
        adcr_pkg::OFS_PIN_LOW:  next_st.pinLow = wrByte; // RULE22
        adcr_pkg::OFS_PIN_HIGH: next_st.pinHigh = wrByte[3:0]; // RULE22
        default:                next_st.c0 = st.c0;
      endcase
    end

    case (st.conv)
      adcr_pkg::CV_IDLE:
        if (next_st.c0.start)
          next_st.conv = adcr_pkg::CV_ARMED;
      adcr_pkg::CV_ARMED:
        if (launch)
          next_st.conv = adcr_pkg::CV_BUSY; // RULE1 RULE2
        else if (!next_st.c0.start)
          next_st.conv = adcr_pkg::CV_IDLE;
      adcr_pkg::CV_BUSY:
        if (finish || !st.c0.converter_enable_bit)
          next_st.conv = next_st.c0.start ? adcr_pkg::CV_ARMED : adcr_pkg::CV_IDLE; // RULE2
      default:
        next_st.conv = adcr_pkg::CV_IDLE;
    endcase
    next_st.c0.conversion_busy_flag = (next_st.conv == adcr_pkg::CV_BUSY); // RULE2 RULE3

    // a disabled converter never overwrites its result
    if (finish && st.c0.converter_enable_bit)
      next_st.result = coreResult; // RULE5

    // conversion clock: one tick every 2^code system clocks, idle when disabled
    next_st.convClkTick = 1'b0;
    if (!st.c0.converter_enable_bit)
      next_st.divCnt = 7'h00;
    else if (st.divCnt >= mask)
    begin
      next_st.divCnt      = 7'h00;
      next_st.convClkTick = 1'b1; // RULE12
    end
    else
      next_st.divCnt = st.divCnt + 7'h01;

    next_st.ctrl.converterOn  = st.c0.converter_enable_bit; // RULE4
    next_st.ctrl.channelRoute = route; // RULE8 RULE10
    next_st.ctrl.pinAnalog    = {st.pinHigh, st.pinLow}; // RULE22
    next_st.ctrl.internalSel  = 6'h00;
    case (st.c1.input_source_field)
      3'h1:    next_st.ctrl.internalSel = 6'h01; // RULE9
      3'h2:    next_st.ctrl.internalSel = 6'h02;
      3'h3:    next_st.ctrl.internalSel = 6'h04;
      3'h5:    next_st.ctrl.internalSel = 6'h08;
      3'h6:    next_st.ctrl.internalSel = 6'h10;
      3'h7:    next_st.ctrl.internalSel = 6'h20;
      default: next_st.ctrl.internalSel = 6'h00;
    endcase
    next_st.ctrl.gainAmpOn  = st.c2.gain_amp_enable; // RULE13
    // the bandgap also serves the voltage monitors, so they keep it powered
    next_st.ctrl.bandgapOn  = (st.c2.bandgap_enable && st.c0.converter_enable_bit)
                           || lvdEnable || lvrEnable; // RULE14
    next_st.ctrl.extRefConnect = st.c2.ext_ref_input_select
                              && (refKind == adcr_pkg::REFK_EXT); // RULE17 RULE20
    next_st.ctrl.refOutDrive   = st.c2.ref_output_select; // RULE18
    next_st.ctrl.refKind       = refKind; // RULE19
    next_st.ctrl.gainBypass    = (refKind == adcr_pkg::REFK_SUPPLY); // RULE21
    case (refKind)
      adcr_pkg::REFK_EXT:
        next_st.ctrl.refGain = st.c2.reference_source_field[2:0]; // RULE19
      adcr_pkg::REFK_BG:
        next_st.ctrl.refGain = 3'(st.c2.reference_source_field - adcr_pkg::REF_BG_OFFSET);
      default:
        next_st.ctrl.refGain = 3'h1;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      st       <= '0; // RULE26
      st.conv  <= adcr_pkg::CV_IDLE;
      st.ctrl.refKind <= adcr_pkg::REFK_SUPPLY;
      st.ctrl.refGain <= 3'h1;
      st.ctrl.gainBypass <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign analogCtrl  = st.ctrl;
  assign convStart   = st.convStart;
  assign convClkTick = st.convClkTick;
  assign convDone    = st.convDone;

  // ==========================================================================
  // checks
  // ==========================================================================
  logic [7:0] gapCnt;
  logic       gapValid;

  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      gapCnt   <= 8'h00;
      gapValid <= 1'b0;
    end
    else if (convClkTick)
    begin
      gapCnt   <= 8'h00;
      gapValid <= 1'b1;
    end
    else
    begin
      gapCnt   <= gapCnt + 8'h01;
      if ($changed(st.c1.clock_divider_field) || !st.c0.converter_enable_bit)
        gapValid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_n);

  launch_busy_a: assert property (launch |=> st.c0.conversion_busy_flag && convStart) // RULE1
    else $error("launch did not raise busy and start");
  no_launch_a: assert property (convStart |-> $past(st.conv) == adcr_pkg::CV_ARMED) // RULE1
    else $error("conversion started without a start pulse");
  busy_clear_a: assert property (finish |=> !st.c0.conversion_busy_flag ##0 convDone) // RULE2
    else $error("busy not cleared on completion");
  busy_ro_a: assert property (wrAccept && avsReq.address == adcr_pkg::OFS_CTRL0 // RULE3
      && !launch && !finish && st.conv != adcr_pkg::CV_BUSY
      |=> !st.c0.conversion_busy_flag)
    else $error("write changed busy flag");
  result_hold_a: assert property (!st.c0.converter_enable_bit |=> $stable(st.result)) // RULE5
    else $error("result changed while disabled");
  res_high_a: assert property ( // RULE6
      avsReq.read && st.ack && avsReq.address == adcr_pkg::OFS_RES_HIGH
      && !st.c0.result_format_bit && $stable(st.result) && $stable(st.c0)
      |-> avsResp.readdata[7:0] == st.result[11:4])
    else $error("high result byte wrong in format 0");
  res_low_a: assert property ( // RULE6
      avsReq.read && st.ack && avsReq.address == adcr_pkg::OFS_RES_LOW
      && st.c0.result_format_bit && $stable(st.result) && $stable(st.c0)
      |-> avsResp.readdata[7:0] == st.result[7:0])
    else $error("low result byte wrong in format 1");
  res_pad_a: assert property ( // RULE7
      avsReq.read && st.ack && avsReq.address == adcr_pkg::OFS_RES_LOW
      && !$past(st.c0.result_format_bit) |-> avsResp.readdata[3:0] == 4'h0)
    else $error("unused result bits not zero");
  chan_off_a: assert property (!isExtSource(st.c1.input_source_field) // RULE10
      || st.c0.external_channel_field > adcr_pkg::CHAN_LAST
      |=> analogCtrl.channelRoute == 12'h000)
    else $error("external channel routed while deselected");
  rsvd_zero_a: assert property (avsReq.read && st.ack // RULE11
      && avsReq.address == adcr_pkg::OFS_CTRL1 |-> avsResp.readdata[4:3] == 2'h0)
    else $error("unimplemented bits read nonzero");
  pin_zero_a: assert property (avsReq.read && st.ack // RULE11
      && avsReq.address == adcr_pkg::OFS_PIN_HIGH |-> avsResp.readdata[7:4] == 4'h0)
    else $error("upper pin enable bits read nonzero");
  div_gap_a: assert property (convClkTick && gapValid // RULE12
      && $stable(st.c1.clock_divider_field) |-> gapCnt == {1'b0, mask})
    else $error("conversion clock divisor wrong");
  bandgap_a: assert property (!lvdEnable && !lvrEnable && !st.c2.bandgap_enable // RULE14
      |=> !analogCtrl.bandgapOn)
    else $error("bandgap left on while unused");
  ext_ref_a: assert property (analogCtrl.extRefConnect |-> analogCtrl.refKind == adcr_pkg::REFK_EXT) // RULE20
    else $error("external reference pin connected for internal reference");
  supply_gain_a: assert property (analogCtrl.refKind == adcr_pkg::REFK_SUPPLY // RULE21
      |-> analogCtrl.gainBypass)
    else $error("supply reference amplified");
  enable_out_a: assert property ( // RULE4
      analogCtrl.converterOn == $past(st.c0.converter_enable_bit))
    else $error("converter power does not follow enable");
  abort_a: assert property ( // RULE2
      st.conv == adcr_pkg::CV_BUSY && !st.c0.converter_enable_bit |=> !st.c0.conversion_busy_flag)
    else $error("busy kept after disable");
  done_busy_a: assert property ( // RULE24
      convDone |-> $past(st.c0.conversion_busy_flag))
    else $error("done pulse without a running conversion");
  pin_map_a: assert property ( // RULE22
      analogCtrl.pinAnalog == {$past(st.pinHigh), $past(st.pinLow)})
    else $error("pin analog enables wrong");
  route_one_a: assert property ( // RULE8
      $onehot0(analogCtrl.channelRoute))
    else $error("more than one channel routed");
  route_sel_a: assert property ( // RULE8
      isExtSource(st.c1.input_source_field) && st.c0.external_channel_field <= adcr_pkg::CHAN_LAST
      |=> analogCtrl.channelRoute != 12'h000)
    else $error("selected channel not routed");
  ext_none_a: assert property ( // RULE9
      isExtSource($past(st.c1.input_source_field)) |-> analogCtrl.internalSel == 6'h00)
    else $error("internal signal selected for external source");
  int_one_a: assert property ( // RULE9
      !isExtSource($past(st.c1.input_source_field)) |-> $onehot(analogCtrl.internalSel))
    else $error("internal source not selected");
  amp_out_a: assert property ( // RULE13
      analogCtrl.gainAmpOn == $past(st.c2.gain_amp_enable))
    else $error("gain amplifier does not follow enable");
  ref_out_a: assert property ( // RULE18
      analogCtrl.refOutDrive == $past(st.c2.ref_output_select))
    else $error("reference output does not follow select");
  ext_sel_a: assert property ( // RULE17
      st.c2.ext_ref_input_select && refKind == adcr_pkg::REFK_EXT |=> analogCtrl.extRefConnect)
    else $error("external reference pin not connected");
  rsvd_ref_a: assert property ( // RULE25
      refKind == adcr_pkg::REFK_NONE |=> analogCtrl.refGain == 3'h1 && !analogCtrl.extRefConnect)
    else $error("reserved reference code selects a source");
  gain_range_a: assert property ( // RULE19
      analogCtrl.refGain >= 3'h1 && analogCtrl.refGain <= 3'h4)
    else $error("reference gain out of range");

  launch_c: cover property (launch ##[1:300] finish);
  format_c: cover property (finish && st.c0.result_format_bit);
  internal_c: cover property (analogCtrl.internalSel != 6'h00 && convStart);
  bgref_c: cover property (analogCtrl.refKind == adcr_pkg::REFK_BG && analogCtrl.bandgapOn);
  divmax_c: cover property (convClkTick && st.c1.clock_divider_field == 3'h7);

endmodule : adcr_control

// [verification/adc_control_register_set_bench.sv]
// self-checking bench for the converter control register set
module adc_control_register_set_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic                     clk;
  logic                     rst_n;
  adcr_pkg::adcr_avs_req_t  req;
  adcr_pkg::adcr_avs_resp_t rsp;
  logic                     coreDone;
  logic [11:0]              coreResult;
  logic                     lvdEnable;
  logic                     lvrEnable;
  adcr_pkg::adcr_analog_t   ana;
  logic                     convStart;
  logic                     convClkTick;
  logic                     convDone;
  int                       errTotal;
  int                       numChecks;
  logic [7:0]               q;
  logic [11:0]              v;
  logic [3:0]               ch;
  logic [2:0]               src;
  logic [7:0]               c2;
  logic [2:0]               kind;
  logic [2:0]               gain;
  int                       n;

  adcr_control adcr_control_i (
    .clk         (clk),
    .rst_n       (rst_n),
    .avsReq      (req),
    .avsResp     (rsp),
    .coreDone    (coreDone),
    .coreResult  (coreResult),
    .lvdEnable   (lvdEnable),
    .lvrEnable   (lvrEnable),
    .analogCtrl  (ana),
    .convStart   (convStart),
    .convClkTick (convClkTick),
    .convDone    (convDone)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic printVerdict;
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : printVerdict

  task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
    numChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // request held until waitrequest is sampled low at a rising edge; read data taken there
  task automatic bus(input bit wr, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}, byteenable: 4'h1};
    @(posedge clk);
    while (rsp.waitrequest !== 1'b0)
    begin
      k++;
      @(posedge clk);
    end
    q = rsp.readdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    chk(1, k, "bus waits");
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
    bus(0, a, 8'h00);
    chk(exp, q, what);
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // result high and low bytes for the given format and value
  function automatic logic [15:0] lay(input logic f, input logic [11:0] x);
    return f ? {4'h0, x} : {x, 4'h0};
  endfunction : lay

  task automatic pulseDone(input logic [11:0] x);
    @(posedge clk);
    coreDone <= 1'b1;
    coreResult <= x;
    @(posedge clk);
    coreDone <= 1'b0;
    @(negedge clk);
  endtask : pulseDone

  initial
  begin
    #400000;
    errTotal++;
    printVerdict();
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    req = '0;
    rst_n = 1'b0;
    coreDone = 1'b0;
    coreResult = 12'h000;
    lvdEnable = 1'b0;
    lvrEnable = 1'b0;
    errTotal = 0;
    numChecks = 0;
    void'($urandom(66));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (n = 0; n < 8; n++)
      rd(5'(n * 4), 8'h00, "reset value");
    bus(1, 5'h1c, 8'(($urandom)));
    rd(5'h1c, 8'h00, "unmapped");
    bus(1, 5'h00, 8'h40);
    rd(5'h00, 8'h00, "busy write");
    c2 = 8'($urandom);
    bus(1, 5'h04, c2);
    rd(5'h04, c2 & 8'he7, "ctrl1 readback");
    bus(1, 5'h0c, c2);
    bus(1, 5'h10, 8'hff);
    rd(5'h10, 8'h0f, "pin high readback");
    settle();
    chk({4'hf, c2}, ana.pinAnalog, "pin analog");
    // start pulse with the converter off must launch nothing
    bus(1, 5'h00, 8'h80);
    bus(1, 5'h00, 8'h00);
    @(negedge clk);
    chk(0, convStart, "start while off");
    for (n = 0; n < 4; n++)
    begin
      v = (n == 0) ? 12'hfff : 12'($urandom);
      // the bandgap stays off here, so no settle wait is owed before a start
      bus(1, 5'h00, {3'b101, n[0], 4'h3});
      bus(1, 5'h00, {3'b001, n[0], 4'h3});
      @(negedge clk);
      chk(1, convStart, "start pulse");
      rd(5'h00, {3'b011, n[0], 4'h3}, "busy set");
      pulseDone(v);
      chk(1, convDone, "done pulse");
      rd(5'h00, {3'b001, n[0], 4'h3}, "busy clear");
      rd(5'h14, 8'(lay(n[0], v) >> 8), "result high");
      rd(5'h18, 8'(lay(n[0], v)), "result low");
    end
    bus(1, 5'h00, 8'h00);
    pulseDone(~v);
    rd(5'h18, 8'(lay(1'b0, v)), "result held");
    chk(0, ana.converterOn, "converter off");
    bus(1, 5'h00, 8'h20);
    for (n = 0; n < 8; n++)
    begin
      bus(1, 5'h04, 8'(n));
      settle();
      for (int k = 0; k < 2; k++)
      begin
        v = 0;
        while (convClkTick !== 1'b1 && v < 300)
        begin
          @(negedge clk);
          v++;
        end
        if (k == 0)
          @(negedge clk);
      end
      chk(1 << n, v + 1, "divider period");
    end
    for (n = 0; n < 24; n++)
    begin
      ch = 4'(n);
      src = (n < 8) ? 3'(n) : ((n < 16) ? 3'h0 : 3'($urandom));
      bus(1, 5'h00, {4'b0010, ch});
      bus(1, 5'h04, {src, 5'h00});
      settle();
      chk(((src[1:0] == 0) && ch < 12) ? 12'h1 << ch : 12'h0, ana.channelRoute, "route");
      chk((src[1:0] == 0) ? 6'h0 : 6'h1 << (src[2] * 3 + src[1:0] - 1), ana.internalSel, "internal");
    end
    for (n = 0; n < 16; n++)
    begin
      c2 = {4'($urandom), 4'(n)};
      c2[6] = c2[6] | (n > 9 && n < 13);
      // pin sharing lives outside this block; the bandgap goes on before its code is chosen
      bus(1, 5'h08, {c2[7:6], 6'h00});
      lvdEnable <= 1'($urandom);
      lvrEnable <= 1'($urandom);
      bus(1, 5'h08, c2);
      settle();
      kind = (n == 0 || n > 12) ? 3'h1 : ((n < 5) ? 3'h2 : ((n > 9) ? 3'h4 : 3'h0));
      gain = (kind == 3'h2) ? 3'(n) : ((kind == 3'h4) ? 3'(n - 8) : 3'h1);
      chk(kind, ana.refKind, "ref kind");
      chk(gain, ana.refGain, "ref gain");
      chk(kind == 3'h1, ana.gainBypass, "gain bypass");
      chk(c2[5] && kind == 3'h2, ana.extRefConnect, "ext ref pin");
      chk({c2[7], c2[4]}, {ana.gainAmpOn, ana.refOutDrive}, "amp and out");
      chk(c2[6] | lvdEnable | lvrEnable, ana.bandgapOn, "bandgap");
      rd(5'h08, c2, "ctrl2 readback");
    end
    printVerdict();
  end
endmodule : adc_control_register_set_bench
